// ===== bench/crcr_host.sv
// Host model standing behind the serial framing engine.
// Assumes the bank samples strobes on the rising master clock edge.
`timescale 1ns/1ps
module crcr_host
  import crcr_pkg::*;
(
  input wire logic clk_sys_in,
  output crcr_reg_req_t req_out,
  output logic read_active_out
);
  // Idle bus at time zero.
  initial begin
    req_out = '0;
    read_active_out = 1'b0;
  end
  // One single-cycle access; released fields are inverted so stale data never looks valid.
  task automatic access(input logic w, input logic [1:0] s, input logic [23:0] d);
    @(posedge clk_sys_in);
    req_out <= '{wr: w, rd: !w, sel: s, data: d};
    @(posedge clk_sys_in);
    req_out <= '{wr: 1'b0, rd: 1'b0, sel: ~s, data: ~d};
  endtask : access
  // Opens or closes a result read, well inside one output period.
  task automatic read_window(input logic on);
    @(posedge clk_sys_in);
    read_active_out <= on;
  endtask : read_window
endmodule : crcr_host

// ===== bench/crcr_regs_chk.sv
// Port assertions for the result and calibration register bank.
// Assumes it is bound onto crcr_regs and sees one clock domain.
`timescale 1ns/1ps
module crcr_regs_chk
  import crcr_pkg::*;
#(
  parameter int READY_HIGH_CYCLES = 12
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire crcr_reg_req_t reg_req_in,
  input wire logic result_read_active_in,
  input wire crcr_conv_t conv_in,
  input wire crcr_cfg_t cfg_in,
  input wire logic [23:0] rd_data_out,
  input wire logic rd_valid_out,
  input wire logic [23:0] conversion_result_out,
  input wire logic result_ready_n_out,
  input wire logic ready_status_out
);
  // Two updates may queue up, so the ready bound covers both.
  localparam int LAT = 2 * READY_HIGH_CYCLES + 12;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);
  // A write, an idle cycle, then a read of the same register.
  sequence s_wr_rd(logic [1:0] s);
    reg_req_in.wr && !reg_req_in.rd && reg_req_in.sel == s ##2 reg_req_in.rd && !reg_req_in.wr && reg_req_in.sel == s;
  endsequence
  // Each result update and read answer is tied to its cause.
  a_update_ready_high: assert property ($changed(conversion_result_out) |-> $past(result_ready_n_out))
    else $error("result changed while ready low");
  a_load_then_low: assert property ($changed(conversion_result_out) |=> !result_ready_n_out)
    else $error("ready not low after update");
  a_status_mirror: assert property (ready_status_out == result_ready_n_out)
    else $error("status differs from ready");
  a_read_answer: assert property (reg_req_in.rd |=> rd_valid_out)
    else $error("read not answered");
  a_ofs_readback: assert property (s_wr_rd(CRCR_SEL_OFFSET) |=> rd_data_out == $past(reg_req_in.data, 3))
    else $error("offset readback wrong");
  a_fs_readback: assert property (s_wr_rd(CRCR_SEL_FULLSCALE) |=> rd_data_out == $past(reg_req_in.data, 3))
    else $error("fullscale readback wrong");
  a_conv_to_ready: assert property (conv_in.valid && !result_read_active_in |-> ##[1:LAT] $fell(result_ready_n_out))
    else $error("no ready after conversion");
  a_release_ready: assert property ($fell(result_read_active_in) && !result_ready_n_out |-> ##[1:2] result_ready_n_out)
    else $error("ready not released");
  a_defer_hold: assert property (result_read_active_in && $past(result_read_active_in) |-> $stable(conversion_result_out))
    else $error("result updated under read");
endmodule : crcr_regs_chk

bind crcr_regs crcr_regs_chk #(.READY_HIGH_CYCLES(READY_HIGH_CYCLES)) u_chk (.clk_sys_in, .resetn_in, .reg_req_in,
  .result_read_active_in, .conv_in, .cfg_in, .rd_data_out, .rd_valid_out, .conversion_result_out,
  .result_ready_n_out, .ready_status_out);

// ===== bench/tb_top.sv
// Self-checking bench for the result and calibration register bank.
// Assumes the host model drives accesses and the bench plays the filter.
`timescale 1ns/1ps
module tb_top;
  import crcr_pkg::*;
  logic clk_sys_in, resetn_in, rdy_n, stat, rd_valid, rd_act;
  crcr_reg_req_t req;
  crcr_conv_t conv;
  crcr_cfg_t cfg;
  logic [23:0] rd_data, res, off, fs, raw, a, b;
  logic [31:0] rng;
  logic [23:0] expq[$];
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  // A short ready hold keeps the run brief.
  crcr_regs #(.READY_HIGH_CYCLES(2)) DUT (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .reg_req_in(req),
    .result_read_active_in(rd_act), .conv_in(conv), .cfg_in(cfg), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
    .conversion_result_out(res), .result_ready_n_out(rdy_n), .ready_status_out(stat));
  crcr_host u_host (.clk_sys_in(clk_sys_in), .req_out(req), .read_active_out(rd_act));
  // Free-running master clock.
  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  // Reference correction, saturated before unipolar limit and coding.
  function automatic logic [23:0] corr(input logic [23:0] r, input logic fmt, input logic uni);
    logic signed [63:0] p;
    p = ($signed({{40{r[23]}}, r}) - $signed({{40{off[23]}}, off})) * $signed({40'h0, fs});
    p = p >>> 22;
    if (p > 64'sh7FFFFF) p = 64'sh7FFFFF;
    if (p < -64'sh800000) p = -64'sh800000;
    if (uni && p < 64'sh0) p = 64'sh0;
    return {p[23] ^ fmt, p[22:0]};
  endfunction : corr
  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t word %h exp %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t ready %b exp %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic rd(input logic [1:0] s, input logic [23:0] e);
    expq.push_back(e);
    u_host.access(1'b0, s, ~e);
  endtask : rd
  task automatic send(input logic [23:0] d);
    @(posedge clk_sys_in);
    conv <= '{valid: 1'b1, data: d};
    @(posedge clk_sys_in);
    conv <= '{valid: 1'b0, data: ~d};
  endtask : send
  task automatic wait_rdy();
    for (int n = 0; n < 100 && rdy_n !== 1'b0; n++) @(posedge clk_sys_in);
    chk_bit(rdy_n, 1'b0);
    chk_bit(stat, 1'b0);
  endtask : wait_rdy
  task automatic give_verdict();
    if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // Read answers are matched against the oldest expectation.
  always @(posedge clk_sys_in) begin
    if (rd_valid === 1'b1) chk_word(rd_data, expq.pop_front());
  end
  // A hang costs a mismatch and ends the run.
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    resetn_in = 1'b1;
    conv = '0;
    cfg = '0;
    rng = 32'h00012404;
    // Dropping reset just after time zero makes the asynchronous clear act before the first edge.
    #1;
    resetn_in = 1'b0;
    repeat (2) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    // Reset values; writes to read-only selects are dropped.
    rd(CRCR_SEL_STATUS, 24'h000001);
    u_host.access(1'b1, CRCR_SEL_RESULT, 24'h123456);
    u_host.access(1'b1, CRCR_SEL_STATUS, 24'hFFFFFF);
    rd(CRCR_SEL_RESULT, CRCR_RESULT_RST);
    rd(CRCR_SEL_OFFSET, CRCR_OFFSET_RST);
    rd(CRCR_SEL_FULLSCALE, CRCR_FULLSCALE_RST);
    // Two calibration runs averaged and written back, then read again.
    rng = xs(rng);
    a = {{6{rng[17]}}, rng[17:0]};
    rng = xs(rng);
    b = {{6{rng[17]}}, rng[17:0]};
    off = ($signed(a) + $signed(b)) >>> 1;
    rng = xs(rng);
    fs = 24'h300000 + {3'h0, rng[20:0]};
    u_host.access(1'b1, CRCR_SEL_OFFSET, off);
    rd(CRCR_SEL_OFFSET, off);
    u_host.access(1'b1, CRCR_SEL_FULLSCALE, fs);
    rd(CRCR_SEL_FULLSCALE, fs);
    // Every coding and polarity over full-scale and random inputs.
    for (int i = 0; i < 12; i++) begin
      rng = xs(rng);
      raw = (i < 4) ? 24'h7FFFFF : (i < 8) ? 24'h800000 : rng[23:0];
      cfg <= '{format_select_bit: i[0], unipolar_select: i[1]};
      send(raw);
      wait_rdy();
      chk_word(res, corr(raw, i[0], i[1]));
      u_host.read_window(1'b1);
      rd(CRCR_SEL_RESULT, corr(raw, i[0], i[1]));
      rd(CRCR_SEL_STATUS, 24'h000000);
      u_host.read_window(1'b0);
      repeat (3) @(posedge clk_sys_in);
      chk_bit(rdy_n, 1'b1);
      chk_bit(stat, 1'b1);
    end
    // An open read holds off updates; the later conversion overwrites the earlier.
    u_host.read_window(1'b1);
    send(24'h000100);
    send(24'h000200);
    repeat (20) @(posedge clk_sys_in);
    chk_bit(rdy_n, 1'b1);
    chk_word(res, corr(raw, 1'b1, 1'b1));
    u_host.read_window(1'b0);
    wait_rdy();
    chk_word(res, corr(24'h000200, 1'b1, 1'b1));
    repeat (5) @(posedge clk_sys_in);
    give_verdict();
  end
endmodule : tb_top

// ===== rtl/crcr_corr_path.sv
// Correction datapath: offset subtraction, full-scale gain, saturation, unipolar limit and output coding.
// Assumes start is a one-cycle pulse and operands stay stable in that cycle only.
`timescale 1ns/1ps
module crcr_corr_path
  import crcr_pkg::*;
#(
  parameter int OFS_SHIFT = 0
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic start_in,
  input wire logic [23:0] raw_in,
  input wire logic [23:0] offset_in,
  input wire logic [23:0] fullscale_in,
  input wire crcr_cfg_t cfg_in,
  output logic valid_out,
  output logic [23:0] result_out
);

  logic signed [24:0] offset_term;
  logic signed [24:0] diff;
  logic signed [49:0] product;
  logic signed [49:0] scaled;
  logic signed [23:0] sat;
  logic [23:0] coded;

  // Offset is two's complement and fullscale unsigned regardless of the output format.
  always_comb begin
    offset_term = $signed({offset_in[23], offset_in}) >>> OFS_SHIFT; // R9 R13
    diff = $signed({raw_in[23], raw_in}) - offset_term; // R7
    product = diff * $signed({1'b0, fullscale_in}); // R10 R12 R13
    scaled = product >>> CRCR_FS_FRAC;
    // Saturating avoids a wrap from full positive to full negative scale.
    if (scaled > 50'sh00000007FFFFF) begin
      sat = 24'sh7FFFFF;
    end else if (scaled < -50'sh0000000800000) begin
      sat = -24'sh800000;
    end else begin
      sat = scaled[23:0];
    end
    if (cfg_in.unipolar_select && sat[23]) begin
      coded = 24'h000000; // R6
    end else begin
      coded = sat;
    end
    if (cfg_in.format_select_bit == CRCR_FMT_OFFSET_BIN) begin
      coded[23] = ~coded[23]; // R5
    end
  end

  // One register stage keeps the wide multiply off the load path.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      valid_out <= 1'b0;
      result_out <= 24'h000000;
    end else begin
      valid_out <= start_in;
      if (start_in) begin
        result_out <= coded;
      end
    end
  end

endmodule : crcr_corr_path

// ===== rtl/crcr_regs.sv
// Conversion result, offset correction and full-scale correction registers with result-ready timing.
// Assumes the serial engine flags a result read with a level and issues single-cycle access strobes.
// Summary of operation
// R1: Hold latest result in 24-bit register.
// R2: Load result just before ready goes low.
// R3: Unread result is overwritten by next conversion.
// R4: Force ready high before update unless reading.
// R5: Result coded two's complement or offset binary.
// R6: Unipolar select clamps result to unipolar values.
// R7: Apply 24-bit offset correction before storing result.
// R8: Offset correction readable and writable by host.
// R9: Offset correction always two's complement.
// R10: Apply 24-bit full-scale correction before storing.
// R11: Full-scale correction readable and writable by host.
// R12: Full-scale correction always unsigned binary.
// R13: Correction is linear function of register value.
// R14: Host may average calibrations and write back.
// R15: Status bit mirrors ready pin, zero means ready.
`timescale 1ns/1ps
module crcr_regs
  import crcr_pkg::*;
#(
  parameter int READY_HIGH_CYCLES = CRCR_READY_HIGH_CYCLES,
  parameter int OFS_SHIFT = 0
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire crcr_reg_req_t reg_req_in,
  input wire logic result_read_active_in,
  input wire crcr_conv_t conv_in,
  input wire crcr_cfg_t cfg_in,
  output logic [23:0] rd_data_out,
  output logic rd_valid_out,
  output logic [23:0] conversion_result_out,
  output logic result_ready_n_out,
  output logic ready_status_out
);

  typedef enum logic [1:0] {
    CRCR_ST_IDLE = 2'b00,
    CRCR_ST_PREP = 2'b01,
    CRCR_ST_CALC = 2'b10,
    CRCR_ST_LOAD = 2'b11
  } crcr_state_t;

  crcr_state_t state_reg;
  crcr_state_t state_next;
  logic [23:0] conversion_result_reg;
  logic [23:0] offset_corr_reg;
  logic [23:0] fullscale_corr_reg;
  logic [23:0] pending_reg;
  logic pending_valid_reg;
  logic [CRCR_PREP_CW-1:0] prep_cnt_reg;
  logic result_ready_n_reg;
  logic read_active_d_reg;
  logic [23:0] rd_data_reg;
  logic rd_valid_reg;
  logic [23:0] calc_raw_reg;
  logic calc_start;
  logic dp_valid;
  logic [23:0] dp_result;
  logic read_end;
  logic prep_done;
  logic snap_take;

  localparam logic [CRCR_PREP_CW-1:0] PREP_LAST = CRCR_PREP_CW'(READY_HIGH_CYCLES - 1);

  assign read_end = read_active_d_reg && !result_read_active_in;
  assign prep_done = (prep_cnt_reg == PREP_LAST);
  assign calc_start = (state_reg == CRCR_ST_PREP) && prep_done;
  assign snap_take = (state_reg == CRCR_ST_IDLE) && (state_next == CRCR_ST_PREP);

  // A fresh conversion replaces any unread pending one; a new arrival beats the consume.
  // The pending flag clears at the snapshot, so a conversion arriving while ready is held high is kept.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pending_reg <= 24'h000000;
      pending_valid_reg <= 1'b0;
    end else begin
      if (conv_in.valid) begin
        pending_reg <= conv_in.data; // R3
        pending_valid_reg <= 1'b1;
      end else if (snap_take) begin
        pending_valid_reg <= 1'b0;
      end
    end
  end

  // Sequencing: wait out any result read, hold ready high, correct, then load.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CRCR_ST_IDLE: begin
        // Deferring during a read keeps the word being shifted out intact.
        if (pending_valid_reg && !result_read_active_in) begin
          state_next = CRCR_ST_PREP; // R4
        end
      end
      CRCR_ST_PREP: begin
        if (prep_done) begin
          state_next = CRCR_ST_CALC;
        end
      end
      CRCR_ST_CALC: begin
        if (dp_valid) begin
          state_next = CRCR_ST_LOAD;
        end
      end
      CRCR_ST_LOAD: begin
        state_next = CRCR_ST_IDLE;
      end
      default: begin
        state_next = CRCR_ST_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= CRCR_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Counts the cycles for which ready is held high ahead of the update.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prep_cnt_reg <= '0;
    end else if (state_reg == CRCR_ST_PREP) begin
      prep_cnt_reg <= prep_cnt_reg + CRCR_PREP_CW'(1);
    end else begin
      prep_cnt_reg <= '0;
    end
  end

  // Snapshot of the raw value so the datapath operand stays fixed while a newer one arrives.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      calc_raw_reg <= 24'h000000;
    end else if (snap_take) begin
      calc_raw_reg <= pending_reg;
    end
  end

  crcr_corr_path #(
    .OFS_SHIFT(OFS_SHIFT)
  ) u_corr_path (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .start_in(calc_start),
    .raw_in(calc_raw_reg),
    .offset_in(offset_corr_reg),
    .fullscale_in(fullscale_corr_reg),
    .cfg_in(cfg_in),
    .valid_out(dp_valid),
    .result_out(dp_result)
  );

  // The result register only changes from the corrected datapath output.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      conversion_result_reg <= CRCR_RESULT_RST;
    end else if (state_reg == CRCR_ST_CALC && dp_valid) begin
      conversion_result_reg <= dp_result; // R1 R2
    end
  end

  // Ready: high on entering the update or at the end of a result read, low the cycle after a load.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      result_ready_n_reg <= 1'b1;
      read_active_d_reg <= 1'b0;
    end else begin
      read_active_d_reg <= result_read_active_in;
      if (state_reg == CRCR_ST_LOAD) begin
        result_ready_n_reg <= 1'b0; // R2
      end else if (state_reg == CRCR_ST_PREP || read_end) begin
        result_ready_n_reg <= 1'b1; // R4
      end
    end
  end

  // Host writes; the result and status selects are not writable and are ignored.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      offset_corr_reg <= CRCR_OFFSET_RST;
      fullscale_corr_reg <= CRCR_FULLSCALE_RST;
    end else if (reg_req_in.wr) begin
      if (reg_req_in.sel == CRCR_SEL_OFFSET) begin
        offset_corr_reg <= reg_req_in.data; // R8 R14
      end
      if (reg_req_in.sel == CRCR_SEL_FULLSCALE) begin
        fullscale_corr_reg <= reg_req_in.data; // R11 R14
      end
    end
  end

  // Host reads return one cycle after the strobe.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_data_reg <= 24'h000000;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= reg_req_in.rd;
      if (reg_req_in.rd) begin
        case (reg_req_in.sel)
          CRCR_SEL_RESULT: begin
            rd_data_reg <= conversion_result_reg;
          end
          CRCR_SEL_OFFSET: begin
            rd_data_reg <= offset_corr_reg; // R8
          end
          CRCR_SEL_FULLSCALE: begin
            rd_data_reg <= fullscale_corr_reg; // R11
          end
          CRCR_SEL_STATUS: begin
            rd_data_reg <= 24'h000000;
            rd_data_reg[CRCR_STATUS_READY_BIT] <= result_ready_n_reg; // R15
          end
          default: begin
            rd_data_reg <= 24'h000000;
          end
        endcase
      end
    end
  end

  // Outputs come straight from flip-flops.
  assign rd_data_out = rd_data_reg;
  assign rd_valid_out = rd_valid_reg;
  assign conversion_result_out = conversion_result_reg;
  assign result_ready_n_out = result_ready_n_reg;
  assign ready_status_out = result_ready_n_reg; // R15

endmodule : crcr_regs

// ===== shared/crcr_pkg.sv
// Shared constants and carrier types for the conversion result and calibration registers.
// Assumes a serial framing engine decodes register selects and a digital filter delivers raw conversions.
package crcr_pkg;

  // Data width of every register in the bank.
  localparam int CRCR_DW = 24;

  // Register select codes presented by the serial framing engine.
  localparam logic [1:0] CRCR_SEL_RESULT = 2'h0;
  localparam logic [1:0] CRCR_SEL_OFFSET = 2'h1;
  localparam logic [1:0] CRCR_SEL_FULLSCALE = 2'h2;
  localparam logic [1:0] CRCR_SEL_STATUS = 2'h3;

  // Position of the ready mirror bit in the status word.
  localparam int CRCR_STATUS_READY_BIT = 0;

  // Reset values; the full-scale value encodes a gain of exactly one.
  localparam logic [23:0] CRCR_OFFSET_RST = 24'h000000;
  localparam logic [23:0] CRCR_FULLSCALE_RST = 24'h400000;
  localparam logic [23:0] CRCR_RESULT_RST = 24'h000000;

  // Full-scale value is an unsigned fixed-point gain with this many fraction bits.
  localparam int CRCR_FS_FRAC = 22;

  // Master-clock periods for which ready is held high before a result update.
  localparam int CRCR_READY_HIGH_CYCLES = 12;
  localparam int CRCR_PREP_CW = 4;

  // Format select encoding.
  localparam logic CRCR_FMT_TWOS = 1'b0;
  localparam logic CRCR_FMT_OFFSET_BIN = 1'b1;

  // One register access from the serial framing engine.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] sel;
    logic [23:0] data;
  } crcr_reg_req_t;

  // One raw conversion from the digital filter.
  typedef struct packed {
    logic valid;
    logic [23:0] data;
  } crcr_conv_t;

  // Configuration bits taken from the command register.
  typedef struct packed {
    logic format_select_bit;
    logic unipolar_select;
  } crcr_cfg_t;

endpackage : crcr_pkg
